// File: pwr_mode_pkg.sv
// Package: register map, field positions, reset values and carrier types of the power-mode block
package pwr_mode_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [7:0] power_control_register_off = 8'h00;
  localparam logic [7:0] pll_control_register_off = 8'h04;
  localparam logic [7:0] wake_status_off = 8'h08;
  localparam logic [7:0] wake_clear_off = 8'h0C;
  localparam logic [7:0] wake_enable_off = 8'h10;
  localparam logic [7:0] mode_status_off = 8'h14;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int idle_bit = 0;
  localparam int power_down_bit = 1;
  localparam int serial_wake_enable_bit = 4;
  localparam int ext_irq_zero_wake_enable_bit = 5;
  localparam int oscillator_halt_bit = 3;
  localparam int ev_idle_exit_bit = 0;
  localparam int ev_pd_exit_bit = 1;
  localparam int ev_width = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [7:0] power_control_rst = 8'h00;
  localparam logic [7:0] pll_control_rst = 8'h00;
  localparam logic [1:0] wake_enable_rst = 2'h0;

  ////////////////////////////////////////////////////////////////////////////
  // AHB encodings
  localparam logic [1:0] htrans_nonseq = 2'h2;
  localparam logic [2:0] hsize_word = 3'h2;

  typedef enum logic [1:0] {
    mode_normal = 2'b00,
    mode_idle = 2'b01,
    mode_power_down = 2'b10
  } mode_t;

  typedef struct packed {
    logic core;
    logic pll;
    logic osc;
    logic periph;
    logic interval;
  } clk_ctl_t;

  typedef struct packed {
    logic hold_ports;
    logic dac_oe;
    logic ale;
    logic program_store_strobe;
  } pin_ctl_t;

  typedef struct packed {
    logic enabled_irq;
    logic interval_counter;
    logic serial;
    logic external_irq_zero;
  } wake_req_t;

endpackage : pwr_mode_pkg

// File: sticky_flags.sv
// Sticky event flags with write-one-to-clear, a new event beats a clear in the same cycle
`timescale 1ns/1ps
module sticky_flags #(
  parameter int width = 2
) (
  input wire logic hclk, // Bus clock
  input wire logic hresetn, // Async reset, active low
  input wire logic [width-1:0] set, // Event pulses
  input wire logic [width-1:0] clr, // Clear strobes
  output logic [width-1:0] flags_ff // Sticky state
);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags_ff <= '0;
    end else begin
      flags_ff <= set | (flags_ff & ~clr);
    end
  end

endmodule : sticky_flags

// File: pwr_mode_ctrl.sv
// Power-mode controller: idle and power-down sequencing, wake-up and AHB-Lite registers
//
// The implementer's own choices: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
module pwr_mode_ctrl (
  input wire logic hclk, // 25 MHz bus clock
  input wire logic hresetn, // Async reset, active low
  input wire logic hsel, // Slave select
  input wire logic [31:0] haddr, // Byte address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write when high
  input wire logic [2:0] hsize, // Transfer size
  input wire logic [31:0] hwdata, // Write data
  input wire logic hready, // Bus ready in
  output logic hreadyout_ff, // Always ready
  output logic hresp_ff, // Always OKAY
  output logic [31:0] hrdata_ff, // Read data
  input wire pwr_mode_pkg::wake_req_t wake_req, // Interrupt requests from the core side
  input wire logic interval_counter_enable, // Interval counter runs in power-down
  input wire logic core_ale, // Address-latch strobe from the core
  input wire logic core_program_store_strobe, // Program-store strobe from the core
  output pwr_mode_pkg::clk_ctl_t clk_ctl_ff, // Clock enables
  output pwr_mode_pkg::pin_ctl_t pin_ctl_ff, // Pin behaviour
  output logic resume_ff, // One-cycle pulse: core resumes with the wake interrupt
  output logic irq_ff // Level interrupt
);

  ////////////////////////////////////////////////////////////////////////////
  // Bus address phase capture

  logic addr_ok;
  logic wr_pend_ff;
  logic [7:0] wr_addr_ff;
  logic [7:0] pwr_ctl_ff;
  logic [7:0] pll_ctl_ff;
  logic [1:0] wake_en_ff;
  logic [pwr_mode_pkg::ev_width-1:0] status_ff;
  logic [pwr_mode_pkg::ev_width-1:0] ev_set;
  logic [pwr_mode_pkg::ev_width-1:0] ev_clr;
  pwr_mode_pkg::mode_t mode_ff;
  pwr_mode_pkg::mode_t nxt_mode;
  logic idle_wake;
  logic pd_wake;
  logic wake;
  logic [31:0] nxt_rdata;

  assign addr_ok = hsel && hready && (htrans == pwr_mode_pkg::htrans_nonseq)
                   && (haddr[31:8] == 24'h000000) && (haddr[1:0] == 2'h0);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
    end else begin
      wr_pend_ff <= addr_ok && hwrite && (hsize == pwr_mode_pkg::hsize_word);
      wr_addr_ff <= haddr[7:0];
    end
  end

  // Zero-wait-state slave; the response never changes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_ff <= 1'b1;
      hresp_ff <= 1'b0;
    end else begin
      hreadyout_ff <= 1'b1;
      hresp_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path, sampled in the address phase so data stands in the data phase

  always_comb begin
    nxt_rdata = 32'h00000000;
    case (haddr[7:0])
      pwr_mode_pkg::power_control_register_off: nxt_rdata[7:0] = pwr_ctl_ff;
      pwr_mode_pkg::pll_control_register_off: nxt_rdata[7:0] = pll_ctl_ff;
      pwr_mode_pkg::wake_status_off: nxt_rdata[1:0] = status_ff;
      pwr_mode_pkg::wake_enable_off: nxt_rdata[1:0] = wake_en_ff;
      pwr_mode_pkg::mode_status_off: nxt_rdata[1:0] = mode_ff;
      default: nxt_rdata = 32'h00000000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_ff <= 32'h00000000;
    end else if (addr_ok && !hwrite) begin
      hrdata_ff <= nxt_rdata;
    end else begin
      hrdata_ff <= 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers

  // Wake clears the mode bits even against a same-cycle write, so a late
  // write cannot send the chip straight back down before the ISR runs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pwr_ctl_ff <= pwr_mode_pkg::power_control_rst;
    end else begin
      if (wr_pend_ff && wr_addr_ff == pwr_mode_pkg::power_control_register_off) begin
        pwr_ctl_ff <= hwdata[7:0];
      end
      if (wake) begin
        pwr_ctl_ff[pwr_mode_pkg::idle_bit] <= 1'b0;
        pwr_ctl_ff[pwr_mode_pkg::power_down_bit] <= 1'b0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pll_ctl_ff <= pwr_mode_pkg::pll_control_rst;
      wake_en_ff <= pwr_mode_pkg::wake_enable_rst;
    end else begin
      if (wr_pend_ff && wr_addr_ff == pwr_mode_pkg::pll_control_register_off) begin
        pll_ctl_ff <= hwdata[7:0];
      end
      if (wr_pend_ff && wr_addr_ff == pwr_mode_pkg::wake_enable_off) begin
        wake_en_ff <= hwdata[1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode state machine

  assign idle_wake = (mode_ff == pwr_mode_pkg::mode_idle) && wake_req.enabled_irq;
  assign pd_wake = (mode_ff == pwr_mode_pkg::mode_power_down)
                   && (wake_req.interval_counter
                       || (wake_req.serial && pwr_ctl_ff[pwr_mode_pkg::serial_wake_enable_bit])
                       || (wake_req.external_irq_zero
                           && pwr_ctl_ff[pwr_mode_pkg::ext_irq_zero_wake_enable_bit]));
  assign wake = idle_wake || pd_wake;

  always_comb begin
    nxt_mode = mode_ff;
    case (mode_ff)
      pwr_mode_pkg::mode_normal: begin
        if (pwr_ctl_ff[pwr_mode_pkg::power_down_bit]) begin
          nxt_mode = pwr_mode_pkg::mode_power_down;
        end else if (pwr_ctl_ff[pwr_mode_pkg::idle_bit]) begin
          nxt_mode = pwr_mode_pkg::mode_idle;
        end
      end
      pwr_mode_pkg::mode_idle: begin
        if (idle_wake) begin
          nxt_mode = pwr_mode_pkg::mode_normal;
        end
      end
      pwr_mode_pkg::mode_power_down: begin
        if (pd_wake) begin
          nxt_mode = pwr_mode_pkg::mode_normal;
        end
      end
      default: nxt_mode = pwr_mode_pkg::mode_normal;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_ff <= pwr_mode_pkg::mode_normal;
    end else begin
      mode_ff <= nxt_mode;
    end
  end

  // The core sees the wake interrupt as it restarts; its return lands after
  // the instruction that set the mode bit, since the program counter is held
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      resume_ff <= 1'b0;
    end else begin
      resume_ff <= wake;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock and pin control, one cycle behind the mode

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clk_ctl_ff <= '1;
    end else begin
      case (mode_ff)
        pwr_mode_pkg::mode_idle: begin
          clk_ctl_ff.core <= 1'b0;
          clk_ctl_ff.pll <= 1'b1;
          clk_ctl_ff.osc <= 1'b1;
          clk_ctl_ff.periph <= 1'b1;
          clk_ctl_ff.interval <= 1'b1;
        end
        pwr_mode_pkg::mode_power_down: begin
          clk_ctl_ff.core <= 1'b0;
          clk_ctl_ff.pll <= 1'b0;
          clk_ctl_ff.osc <= !pll_ctl_ff[pwr_mode_pkg::oscillator_halt_bit];
          clk_ctl_ff.periph <= 1'b0;
          clk_ctl_ff.interval <= interval_counter_enable;
        end
        default: begin
          clk_ctl_ff <= '1;
        end
      endcase
    end
  end

  // Holding the core clock freezes the processor registers in place
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_ctl_ff.hold_ports <= 1'b0;
      pin_ctl_ff.dac_oe <= 1'b1;
      pin_ctl_ff.ale <= 1'b1;
      pin_ctl_ff.program_store_strobe <= 1'b1;
    end else begin
      case (mode_ff)
        pwr_mode_pkg::mode_idle: begin
          pin_ctl_ff.hold_ports <= 1'b1;
          pin_ctl_ff.dac_oe <= 1'b1;
          pin_ctl_ff.ale <= 1'b1;
          pin_ctl_ff.program_store_strobe <= 1'b1;
        end
        pwr_mode_pkg::mode_power_down: begin
          pin_ctl_ff.hold_ports <= 1'b1;
          pin_ctl_ff.dac_oe <= 1'b0;
          pin_ctl_ff.ale <= 1'b0;
          pin_ctl_ff.program_store_strobe <= 1'b0;
        end
        default: begin
          pin_ctl_ff.hold_ports <= 1'b0;
          pin_ctl_ff.dac_oe <= 1'b1;
          pin_ctl_ff.ale <= core_ale;
          pin_ctl_ff.program_store_strobe <= core_program_store_strobe;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wake event flags and interrupt

  always_comb begin
    ev_set = '0;
    ev_set[pwr_mode_pkg::ev_idle_exit_bit] = idle_wake;
    ev_set[pwr_mode_pkg::ev_pd_exit_bit] = pd_wake;
    ev_clr = '0;
    if (wr_pend_ff && wr_addr_ff == pwr_mode_pkg::wake_clear_off) begin
      ev_clr = hwdata[1:0];
    end
  end

  sticky_flags #(
    .width(pwr_mode_pkg::ev_width)
  ) u_flags (
    .hclk(hclk),
    .hresetn(hresetn),
    .set(ev_set),
    .clr(ev_clr),
    .flags_ff(status_ff)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(status_ff & wake_en_ff);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  enter_idle_a: assert property (mode_ff == pwr_mode_pkg::mode_normal
    && pwr_ctl_ff[pwr_mode_pkg::idle_bit] && !pwr_ctl_ff[pwr_mode_pkg::power_down_bit]
    |=> mode_ff == pwr_mode_pkg::mode_idle) else $error("idle not entered");
  both_bits_pd_a: assert property ((mode_ff == pwr_mode_pkg::mode_normal)
    && pwr_ctl_ff[pwr_mode_pkg::power_down_bit] |=> mode_ff == pwr_mode_pkg::mode_power_down)
    else $error("power-down not entered");
  idle_clocks_a: assert property (mode_ff == pwr_mode_pkg::mode_idle
    ##1 mode_ff == pwr_mode_pkg::mode_idle
    |-> !clk_ctl_ff.core && clk_ctl_ff.osc && clk_ctl_ff.periph)
    else $error("idle clock gating wrong");
  idle_pins_a: assert property ($past(mode_ff) == pwr_mode_pkg::mode_idle
    |-> pin_ctl_ff.ale && pin_ctl_ff.program_store_strobe && pin_ctl_ff.hold_ports)
    else $error("idle pins wrong");
  idle_wake_a: assert property (mode_ff == pwr_mode_pkg::mode_idle && wake_req.enabled_irq
    |=> mode_ff == pwr_mode_pkg::mode_normal && resume_ff
    && !pwr_ctl_ff[pwr_mode_pkg::idle_bit] && !pwr_ctl_ff[pwr_mode_pkg::power_down_bit])
    else $error("idle wake missed");
  pd_clocks_a: assert property ($past(mode_ff) == pwr_mode_pkg::mode_power_down
    |-> !clk_ctl_ff.core && !clk_ctl_ff.pll && !clk_ctl_ff.periph
        && clk_ctl_ff.osc == !$past(pll_ctl_ff[pwr_mode_pkg::oscillator_halt_bit]))
    else $error("power-down clocks wrong");
  pd_pins_a: assert property ($past(mode_ff) == pwr_mode_pkg::mode_power_down
    |-> !pin_ctl_ff.dac_oe && !pin_ctl_ff.ale && !pin_ctl_ff.program_store_strobe)
    else $error("power-down pins wrong");
  serial_gate_a: assert property (mode_ff == pwr_mode_pkg::mode_power_down
    && !wake_req.interval_counter && !wake_req.external_irq_zero
    && !pwr_ctl_ff[pwr_mode_pkg::serial_wake_enable_bit]
    |=> mode_ff == pwr_mode_pkg::mode_power_down) else $error("ungated serial wake");
  interval_wake_a: assert property (mode_ff == pwr_mode_pkg::mode_power_down
    && wake_req.interval_counter |=> mode_ff == pwr_mode_pkg::mode_normal ##1
    clk_ctl_ff.core)
    else $error("interval wake missed");
  ext_wake_a: assert property (mode_ff == pwr_mode_pkg::mode_power_down
    && wake_req.external_irq_zero && pwr_ctl_ff[pwr_mode_pkg::ext_irq_zero_wake_enable_bit]
    |=> resume_ff) else $error("external wake missed");

  idle_cycle_c: cover property (mode_ff == pwr_mode_pkg::mode_idle ##1
    mode_ff == pwr_mode_pkg::mode_normal);
  pd_cycle_c: cover property (mode_ff == pwr_mode_pkg::mode_power_down ##1
    mode_ff == pwr_mode_pkg::mode_normal);
  irq_c: cover property (irq_ff);

endmodule : pwr_mode_ctrl

// File: power_saving_mode_control_tb_top.sv
// Self-checking testbench of the power-mode controller, driven over AHB-Lite
`timescale 1ns/1ps
module power_saving_mode_control_tb_top;
  localparam logic [7:0] a_pwr = pwr_mode_pkg::power_control_register_off;
  localparam logic [7:0] a_pll = pwr_mode_pkg::pll_control_register_off;
  localparam logic [7:0] a_st = pwr_mode_pkg::wake_status_off;
  localparam logic [7:0] a_clr = pwr_mode_pkg::wake_clear_off;
  localparam logic [7:0] a_en = pwr_mode_pkg::wake_enable_off;
  localparam logic [7:0] a_mode = pwr_mode_pkg::mode_status_off;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout_ff, hresp_ff;
  logic [31:0] haddr, hwdata, hrdata_ff;
  logic [1:0] htrans;
  logic [2:0] hsize;
  pwr_mode_pkg::wake_req_t wake_req;
  pwr_mode_pkg::clk_ctl_t clk_ctl_ff;
  pwr_mode_pkg::pin_ctl_t pin_ctl_ff;
  logic ice, core_ale, core_pss, resume_ff, irq_ff, rd_dp, pt_req;
  logic [31:0] rd_q[$];
  logic [9:0] pt_q[$];
  logic res_q[$];
  int n_errors, cmp_count;
  logic [7:0] pll_v;
  logic [7:0] pwr_tab[4] = '{8'h02, 8'h12, 8'h22, 8'h03};
  logic [3:0] wake_tab[4] = '{4'h4, 4'h2, 4'h1, 4'h4};

  assign hready = hreadyout_ff;

  pwr_mode_ctrl dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout_ff(hreadyout_ff), .hresp_ff(hresp_ff), .hrdata_ff(hrdata_ff),
    .wake_req(wake_req), .interval_counter_enable(ice), .core_ale(core_ale),
    .core_program_store_strobe(core_pss), .clk_ctl_ff(clk_ctl_ff), .pin_ctl_ff(pin_ctl_ff),
    .resume_ff(resume_ff), .irq_ff(irq_ff)
  );

  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    if (res_q.size() != 0) begin
      n_errors++;
      $display("[FAIL] %0t expected resume pulse never came", $time);
    end
    if (n_errors == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finish_test

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : cmp

  // Single transfer; waits on hready rather than assuming zero wait states
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
                     input logic [2:0] sz);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= pwr_mode_pkg::htrans_nonseq;
    hwrite <= w;
    hsize <= sz;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= w ? d : 32'h0;
    rd_dp <= !w;
    if (!w) rd_q.push_back(d);
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rd_dp <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d, pwr_mode_pkg::hsize_word);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    bus(a, 1'b0, exp, pwr_mode_pkg::hsize_word);
  endtask : rd

  task automatic ports(input logic [4:0] c, input logic [3:0] p, input logic irq);
    pt_q.push_back({c, p, irq});
    pt_req <= 1'b1;
    @(posedge hclk);
    pt_req <= 1'b0;
    @(posedge hclk);
  endtask : ports

  // Fresh core strobes each time, so a stuck pass-through shows up
  task automatic chk_normal(input logic irq);
    core_ale <= 1'($urandom);
    core_pss <= 1'($urandom);
    repeat (3) @(posedge hclk);
    ports(5'h1F, {2'b01, core_ale, core_pss}, irq);
  endtask : chk_normal

  task automatic wake(input logic [3:0] req, input logic exp_resume);
    if (exp_resume) res_q.push_back(1'b1);
    wake_req <= pwr_mode_pkg::wake_req_t'(req);
    repeat (2) @(posedge hclk);
    wake_req <= pwr_mode_pkg::wake_req_t'(4'h0);
    repeat (6) @(posedge hclk);
  endtask : wake

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge hclk) begin
    if (rd_dp === 1'b1) cmp(hrdata_ff, rd_q.pop_front(), "read data");
    if (rd_dp === 1'b1) cmp({31'h0, hresp_ff}, 32'h0, "bus response");
    if (pt_req === 1'b1) cmp({22'h0, clk_ctl_ff, pin_ctl_ff, irq_ff}, {22'h0, pt_q.pop_front()},
                             "clock and pin control");
    if (resume_ff === 1'b1) begin
      cmp_count++;
      if (res_q.size() == 0) begin
        n_errors++;
        $display("[FAIL] %0t resume pulse without a wake-up", $time);
      end else begin
        void'(res_q.pop_front());
      end
    end
  end

  initial begin
    #240000;
    n_errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    finish_test();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = pwr_mode_pkg::hsize_word;
    hwdata = 32'h0;
    wake_req = pwr_mode_pkg::wake_req_t'(4'h0);
    ice = 1'b0;
    core_ale = 1'b1;
    core_pss = 1'b1;
    rd_dp = 1'b0;
    pt_req = 1'b0;
    n_errors = 0;
    cmp_count = 0;
    void'($urandom(41276));
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int a = 0; a <= 'h18; a += 4) rd(8'(a), 32'h0);
    chk_normal(1'b0);
    bus(a_pwr, 1'b1, 32'h1, 3'h0);
    rd(a_pwr, 32'h0);
    wr(a_pwr, 32'h1);
    repeat (3) @(posedge hclk);
    rd(a_mode, 32'h1);
    ports(5'h0F, 4'hF, 1'b0);
    wake(4'h8, 1'b1);
    rd(a_st, 32'h1);
    rd(a_mode, 32'h0);
    rd(a_pwr, 32'h0);
    chk_normal(1'b0);
    for (int i = 0; i < 4; i++) begin
      pll_v = 8'($urandom) & 8'hF7 | {4'h0, i[0], 3'h0};
      wr(a_pll, {24'h0, pll_v});
      rd(a_pll, {24'h0, pll_v});
      ice <= i[1];
      wr(a_pwr, {24'h0, pwr_tab[i]});
      repeat (3) @(posedge hclk);
      rd(a_mode, 32'h2);
      ports({2'b00, ~pll_v[3], 1'b0, ice}, 4'b1000, 1'b0);
      if (i == 0) wake(4'hB, 1'b0);
      wake(wake_tab[i], 1'b1);
      rd(a_mode, 32'h0);
      rd(a_pwr, {24'h0, pwr_tab[i] & 8'hFC});
    end
    rd(a_st, 32'h3);
    wr(a_en, 32'h3);
    chk_normal(1'b1);
    wr(a_clr, 32'h1);
    rd(a_st, 32'h2);
    wr(a_en, 32'h1);
    chk_normal(1'b0);
    wr(a_en, 32'h2);
    rd(a_en, 32'h2);
    chk_normal(1'b1);
    wr(a_clr, 32'h3);
    rd(a_st, 32'h0);
    chk_normal(1'b0);
    // Requests seen in normal mode must not wake anything
    wake(4'hF, 1'b0);
    rd(a_st, 32'h0);
    wr(a_pwr, 32'h2);
    repeat (3) @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk_normal(1'b0);
    rd(a_pwr, 32'h0);
    rd(a_pll, 32'h0);
    rd(a_en, 32'h0);
    finish_test();
  end
endmodule : power_saving_mode_control_tb_top
